/* i2c_mt_map.svh */
// Register offsets, field positions, reset values, status codes and timing for the transmit sequencer
`ifndef I2C_MT_MAP_SVH
`define I2C_MT_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define I2C_OFS_CTRL 12'h000
`define I2C_OFS_STATUS 12'h004
`define I2C_OFS_DATA 12'h008
`define I2C_OFS_EVENT 12'h00C
`define I2C_OFS_MASK 12'h010
// ----------------------------------------
// Control bits and reset values
// ----------------------------------------
`define I2C_CTRL_FLAG 7
`define I2C_CTRL_STOP 4
`define I2C_CTRL_RST 8'h00
`define I2C_STATUS_RST 8'hF8
`define I2C_DATA_RST 8'hFF
// ----------------------------------------
// Event bits
// ----------------------------------------
`define I2C_EV_FLAG 0
`define I2C_EV_WCOL 1
`define I2C_EV_ARB 2
// ----------------------------------------
// Status codes, prescaler bits zero
// ----------------------------------------
`define I2C_ST_START 8'h08
`define I2C_ST_RSTART 8'h10
`define I2C_ST_AW_ACK 8'h18
`define I2C_ST_AW_NACK 8'h20
`define I2C_ST_D_ACK 8'h28
`define I2C_ST_D_NACK 8'h30
`define I2C_ST_ARB 8'h38
`define I2C_ST_AR_ACK 8'h40
`define I2C_ST_AR_NACK 8'h48
// ----------------------------------------
// Timing
// ----------------------------------------
`define I2C_CLK_PERIOD_NS 10
`define I2C_T_QUARTER_NS 2500
`endif

/* i2c_mt_pkg.sv */
// Types shared by the transmit sequencer
package i2c_mt_pkg;
  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start;
    logic stop;
    logic wcol;
    logic en;
    logic rsvd;
    logic ie;
  } ctrl_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_in_t;
  typedef struct packed {
    logic scl_oe_n;
    logic sda_oe_n;
  } i2c_out_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WAIT_FREE = 4'b0001,
    ST_START = 4'b0010,
    ST_HOLD = 4'b0011,
    ST_BIT_LOW = 4'b0100,
    ST_BIT_HIGH = 4'b0101,
    ST_RS_REL = 4'b0110,
    ST_RS_SCL = 4'b0111,
    ST_STOP_LOW = 4'b1000,
    ST_STOP_SCL = 4'b1001,
    ST_STOP_END = 4'b1010,
    ST_LOST = 4'b1011
  } state_t;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_MT = 2'b01,
    MODE_MR = 2'b10
  } mode_t;
endpackage

/* i2c_mt_seq.sv */
// Byte-oriented two-wire master transmit sequencer with APB registers
//
// Summary of operation
// - write bit selects transmit, read bit receive mode
// - drive START once the bus is free
// - after START set flag, status 0x08
// - writing one clears flag, zero keeps it
// - after address byte flag set: 0x18/0x20/0x38
// - 0x18 address acknowledged, 0x20 not acknowledged
// - data write with flag low discarded, collision set
// - data byte gives 0x28 ack, 0x30 nack
// - repeat load and clear; end with STOP/repeated START
// - stop request sends STOP, stop bit self-clears
// - start and stop together: STOP then START
// - repeated START reports 0x10
// - address with read bit enters receive mode
// - arbitration loss reports 0x38, release or restart
// - transfer suspended while control flag set
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "i2c_mt_map.svh"
module i2c_mt_seq #(
  parameter int QUARTER_NS = `I2C_T_QUARTER_NS
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Two-wire bus, open drain
  input wire i2c_mt_pkg::i2c_in_t I_BUS,
  output i2c_mt_pkg::i2c_out_t O_BUS,
  output logic [1:0] O_MODE,
  // Interrupt
  output logic O_IRQ
);
  import i2c_mt_pkg::*;

  localparam int QUART = (QUARTER_NS + `I2C_CLK_PERIOD_NS - 1) / `I2C_CLK_PERIOD_NS;
  localparam logic [15:0] QLOAD = 16'((QUART < 1 ? 1 : QUART) - 1);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  ctrl_t ctrl_q;
  state_t state_q;
  mode_t mode_q;
  i2c_in_t pin_m_q, pin_s_q;
  i2c_out_t bus_q;
  logic [7:0] status_q, data_q, shift_q, prdata_q;
  logic [2:0] event_q, mask_q;
  logic [3:0] bit_q;
  logic [15:0] tmr_q;
  logic sda_d_q, busy_q, set_flag_q, clr_stop_q, arb_ev_q, rep_q, addr_q, read_q;
  logic wr, rd_setup, ctrl_wr, data_wr, event_wr, mask_wr, mapped;
  logic tick, bus_free, go, scl_s, sda_s;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign ctrl_wr = wr && hit(I_PADDR, `I2C_OFS_CTRL);
  assign data_wr = wr && hit(I_PADDR, `I2C_OFS_DATA);
  assign event_wr = wr && hit(I_PADDR, `I2C_OFS_EVENT);
  assign mask_wr = wr && hit(I_PADDR, `I2C_OFS_MASK);
  assign mapped = hit(I_PADDR, `I2C_OFS_CTRL) || hit(I_PADDR, `I2C_OFS_STATUS) ||
                  hit(I_PADDR, `I2C_OFS_DATA) || hit(I_PADDR, `I2C_OFS_EVENT) || hit(I_PADDR, `I2C_OFS_MASK);
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign O_PRDATA = {24'h000000, prdata_q};

  // Read data is latched in the setup cycle so it comes from a flop
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prdata_q <= 8'h00;
    end else if (rd_setup) begin
      if (hit(I_PADDR, `I2C_OFS_CTRL)) begin
        prdata_q <= ctrl_q;
      end else if (hit(I_PADDR, `I2C_OFS_STATUS)) begin
        prdata_q <= status_q;
      end else if (hit(I_PADDR, `I2C_OFS_DATA)) begin
        prdata_q <= data_q;
      end else if (hit(I_PADDR, `I2C_OFS_EVENT)) begin
        prdata_q <= {5'h00, event_q};
      end else if (hit(I_PADDR, `I2C_OFS_MASK)) begin
        prdata_q <= {5'h00, mask_q};
      end else begin
        prdata_q <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Hardware sets win over software clears in the same cycle
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_q <= `I2C_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.ack_en <= I_PWDATA[6];
        ctrl_q.start <= I_PWDATA[5];
        ctrl_q.stop <= I_PWDATA[`I2C_CTRL_STOP];
        ctrl_q.en <= I_PWDATA[2];
        ctrl_q.ie <= I_PWDATA[0];
        if (I_PWDATA[`I2C_CTRL_FLAG] && !set_flag_q) begin
          ctrl_q.flag <= 1'b0;
        end
      end
      if (set_flag_q) begin
        ctrl_q.flag <= 1'b1;
      end
      if (clr_stop_q) begin
        ctrl_q.stop <= 1'b0;
      end
      if (data_wr) begin
        // A data write with the flag high clears an old collision
        ctrl_q.wcol <= !ctrl_q.flag;
      end
    end
  end

  // Data register; loads only while the flag is up
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      data_q <= `I2C_DATA_RST;
    end else if (data_wr && ctrl_q.flag) begin
      data_q <= I_PWDATA[7:0];
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      event_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      if (mask_wr) begin
        mask_q <= I_PWDATA[2:0];
      end
      event_q <= (event_q & ~(event_wr ? I_PWDATA[2:0] : 3'h0)) |
                 {arb_ev_q, data_wr && !ctrl_q.flag, set_flag_q};
    end
  end
  assign O_IRQ = (ctrl_q.flag && ctrl_q.ie) || |(event_q & mask_q);

  // ----------------------------------------
  // Pin synchroniser and bus busy tracking
  // ----------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pin_m_q <= 2'b11;
      pin_s_q <= 2'b11;
      sda_d_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      pin_m_q <= I_BUS;
      pin_s_q <= pin_m_q;
      sda_d_q <= pin_s_q.sda;
      if (pin_s_q.scl && sda_d_q && !pin_s_q.sda) begin
        busy_q <= 1'b1;
      end else if (pin_s_q.scl && !sda_d_q && pin_s_q.sda) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign scl_s = pin_s_q.scl;
  assign sda_s = pin_s_q.sda;
  assign bus_free = !busy_q && scl_s && sda_s;
  assign tick = (tmr_q == 16'h0000);
  // resume only once the flag is down and no set is pending
  assign go = !ctrl_q.flag && !set_flag_q;
  assign O_BUS = bus_q;
  assign O_MODE = mode_q;

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  // SCL high phase counts only while the line is seen high, so slaves may stretch
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q <= ST_IDLE;
      mode_q <= MODE_NONE;
      bus_q <= 2'b11;
      status_q <= `I2C_STATUS_RST;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      tmr_q <= 16'h0000;
      set_flag_q <= 1'b0;
      clr_stop_q <= 1'b0;
      arb_ev_q <= 1'b0;
      rep_q <= 1'b0;
      addr_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      set_flag_q <= 1'b0;
      clr_stop_q <= 1'b0;
      arb_ev_q <= 1'b0;
      if (!tick && !(state_q == ST_BIT_HIGH && !scl_s)) begin
        tmr_q <= tmr_q - 16'h0001;
      end
      if (!ctrl_q.en) begin
        state_q <= ST_IDLE;
        bus_q <= 2'b11;
      end else begin
        case (state_q)
          ST_IDLE: begin
            bus_q <= 2'b11;
            if (ctrl_q.start && go) begin
              state_q <= ST_WAIT_FREE;
              rep_q <= 1'b0;
              tmr_q <= QLOAD;
            end
          end
          ST_WAIT_FREE: begin
            if (!bus_free) begin
              tmr_q <= QLOAD;
            end else if (tick) begin
              bus_q.sda_oe_n <= 1'b0;
              state_q <= ST_START;
              tmr_q <= QLOAD;
            end
          end
          ST_START: begin
            if (tick) begin
              bus_q.scl_oe_n <= 1'b0;
              status_q <= rep_q ? `I2C_ST_RSTART : `I2C_ST_START;
              set_flag_q <= 1'b1;
              addr_q <= 1'b1;
              state_q <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (go) begin
              tmr_q <= QLOAD;
              if (ctrl_q.stop) begin
                bus_q.sda_oe_n <= 1'b0;
                clr_stop_q <= 1'b1;
                state_q <= ST_STOP_LOW;
              end else if (ctrl_q.start) begin
                bus_q.sda_oe_n <= 1'b1;
                state_q <= ST_RS_REL;
              end else begin
                shift_q <= data_q;
                read_q <= data_q[0];
                bus_q.sda_oe_n <= data_q[7];
                bit_q <= 4'h0;
                state_q <= ST_BIT_LOW;
              end
            end
          end
          ST_BIT_LOW: begin
            // SDA moves a cycle after SCL fell, so no slave sees a false START or STOP
            bus_q.sda_oe_n <= bit_q == 4'h8 ? 1'b1 : shift_q[7];
            if (tick) begin
              bus_q.scl_oe_n <= 1'b1;
              tmr_q <= QLOAD;
              state_q <= ST_BIT_HIGH;
            end
          end
          ST_BIT_HIGH: begin
            if (tick && scl_s) begin
              tmr_q <= QLOAD;
              if (bit_q != 4'h8 && bus_q.sda_oe_n && !sda_s) begin
                bus_q <= 2'b11;
                status_q <= `I2C_ST_ARB;
                set_flag_q <= 1'b1;
                arb_ev_q <= 1'b1;
                mode_q <= MODE_NONE;
                state_q <= ST_LOST;
              end else if (bit_q == 4'h8) begin
                bus_q.scl_oe_n <= 1'b0;
                set_flag_q <= 1'b1;
                addr_q <= 1'b0;
                state_q <= ST_HOLD;
                if (addr_q && read_q) begin
                  mode_q <= MODE_MR;
                  status_q <= sda_s ? `I2C_ST_AR_NACK : `I2C_ST_AR_ACK;
                end else if (addr_q) begin
                  mode_q <= MODE_MT;
                  status_q <= sda_s ? `I2C_ST_AW_NACK : `I2C_ST_AW_ACK;
                end else begin
                  status_q <= sda_s ? `I2C_ST_D_NACK : `I2C_ST_D_ACK;
                end
              end else begin
                bus_q.scl_oe_n <= 1'b0;
                shift_q <= {shift_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
                state_q <= ST_BIT_LOW;
              end
            end
          end
          ST_RS_REL: begin
            if (tick) begin
              bus_q.scl_oe_n <= 1'b1;
              tmr_q <= QLOAD;
              state_q <= ST_RS_SCL;
            end
          end
          ST_RS_SCL: begin
            if (!scl_s) begin
              tmr_q <= QLOAD;
            end else if (tick) begin
              bus_q.sda_oe_n <= 1'b0;
              rep_q <= 1'b1;
              tmr_q <= QLOAD;
              state_q <= ST_START;
            end
          end
          ST_STOP_LOW: begin
            if (tick) begin
              bus_q.scl_oe_n <= 1'b1;
              tmr_q <= QLOAD;
              state_q <= ST_STOP_SCL;
            end
          end
          ST_STOP_SCL: begin
            if (!scl_s) begin
              tmr_q <= QLOAD;
            end else if (tick) begin
              bus_q.sda_oe_n <= 1'b1;
              tmr_q <= QLOAD;
              state_q <= ST_STOP_END;
            end
          end
          ST_STOP_END: begin
            if (tick) begin
              mode_q <= MODE_NONE;
              rep_q <= 1'b0;
              tmr_q <= QLOAD;
              state_q <= ctrl_q.start ? ST_WAIT_FREE : ST_IDLE;
            end
          end
          ST_LOST: begin
            bus_q <= 2'b11;
            if (go) begin
              rep_q <= 1'b0;
              tmr_q <= QLOAD;
              state_q <= ctrl_q.start ? ST_WAIT_FREE : ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  a_flag_clear_one: assert property (ctrl_wr && I_PWDATA[`I2C_CTRL_FLAG] && !set_flag_q |=> !ctrl_q.flag)
    else $error("flag not cleared by write of one");
  a_flag_keep_zero: assert property (ctrl_wr && !I_PWDATA[`I2C_CTRL_FLAG] && ctrl_q.flag |=> ctrl_q.flag)
    else $error("flag lost on write of zero");
  a_wcol_discard: assert property (data_wr && !ctrl_q.flag |=> ctrl_q.wcol && $stable(data_q))
    else $error("collision write not discarded");
  a_start_free: assert property (state_q == ST_WAIT_FREE && !bus_free |=> state_q != ST_START)
    else $error("START driven on busy bus");
  a_start_code: assert property (state_q == ST_START && tick && !rep_q |=> status_q == `I2C_ST_START ##1 ctrl_q.flag)
    else $error("START status or flag wrong");
  a_rstart_code: assert property (state_q == ST_START && tick && rep_q |=> status_q == `I2C_ST_RSTART)
    else $error("repeated START status wrong");
  a_addr_status: assert property (state_q == ST_BIT_HIGH && bit_q == 4'h8 && tick && scl_s && addr_q && !read_q
    |=> (status_q == `I2C_ST_AW_ACK || status_q == `I2C_ST_AW_NACK) && mode_q == MODE_MT ##1 ctrl_q.flag)
    else $error("address status wrong");
  a_data_status: assert property (state_q == ST_BIT_HIGH && bit_q == 4'h8 && tick && scl_s && !addr_q
    |=> status_q == ($past(sda_s) ? `I2C_ST_D_NACK : `I2C_ST_D_ACK))
    else $error("data status wrong");
  a_read_mode: assert property (state_q == ST_BIT_HIGH && bit_q == 4'h8 && tick && scl_s && addr_q && read_q
    |=> mode_q == MODE_MR)
    else $error("read address did not enter receive mode");
  a_hold_suspend: assert property (state_q == ST_HOLD && !go |=> state_q == ST_HOLD && !O_BUS.scl_oe_n)
    else $error("transfer moved while flag set");
  a_stop_clear: assert property (state_q == ST_HOLD && go && ctrl_q.stop |=> ##1 !ctrl_q.stop)
    else $error("stop bit not cleared");
  a_arb_code: assert property (state_q != ST_LOST ##1 state_q == ST_LOST |-> status_q == `I2C_ST_ARB && O_BUS == 2'b11)
    else $error("arbitration loss not reported");
  a_irq_level: assert property (ctrl_q.flag && ctrl_q.ie |-> O_IRQ)
    else $error("interrupt missing");
  a_sda_steady: assert property (state_q == ST_BIT_HIGH && ctrl_q.en
    |=> O_BUS.sda_oe_n == $past(O_BUS.sda_oe_n) || state_q == ST_LOST)
    else $error("data line moved while clock high");

  c_start_sent: cover property (state_q == ST_START ##1 state_q == ST_HOLD);
  c_data_ack: cover property (state_q == ST_HOLD && status_q == `I2C_ST_D_ACK);
  c_stop_start: cover property (state_q == ST_STOP_END ##1 state_q == ST_WAIT_FREE);
  c_arb_lost: cover property (state_q == ST_LOST);
endmodule // i2c_mt_seq

/* i2c_slave_rx_model.sv */
// Two-wire slave receiver model that acknowledges or refuses each byte
`timescale 1ns/1ns
module i2c_slave_rx_model (
  // Resolved bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack,
  // Pull-down request and observed traffic
  output logic o_pull,
  output logic [7:0] o_byte,
  output int o_stops
);
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  initial begin
    o_pull = 1'b0;
    o_byte = 8'h00;
    o_stops = 0;
    bit_q = 4'h0;
    shift_q = 8'h00;
  end
  // ----------------------------------------
  // Framing: SDA edges while SCL is high
  // ----------------------------------------
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      bit_q = 4'h0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      o_stops++;
      bit_q = 4'h0;
    end
  end
  // ----------------------------------------
  // Bits, MSB first, and the ninth clock
  // ----------------------------------------
  always @(posedge i_scl) begin
    if (bit_q < 4'h8) begin
      shift_q = {shift_q[6:0], i_sda};
      bit_q++;
    end
  end
  // SDA is let go on the next low phase so the master owns it again
  always @(negedge i_scl) begin
    if (bit_q == 4'h8) begin
      o_byte = shift_q;
      o_pull = ~i_nack;
      bit_q = 4'h9;
    end else if (bit_q == 4'h9) begin
      o_pull = 1'b0;
      bit_q = 4'h0;
    end
  end
endmodule // i2c_slave_rx_model

/* i2c_master_transmit_sequencer_tb.sv */
// Self-checking bench for the transmit sequencer
`timescale 1ns/1ns
`include "i2c_mt_map.svh"
module i2c_master_transmit_sequencer_tb;
  import i2c_mt_pkg::*;
  typedef struct {
    logic has_d;
    logic [7:0] d;
    logic [7:0] ctrl;
    logic nack;
    logic [7:0] st;
    logic [1:0] mode;
  } row_t;
  logic I_CLOCK, I_RSTN, psel, penable, pwrite, nack, other_pull, perr, slv_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata, O_PRDATA;
  logic O_PREADY, O_PSLVERR, O_IRQ, scl_w, sda_w;
  logic [1:0] O_MODE;
  logic [7:0] slv_byte;
  i2c_in_t bus_in;
  i2c_out_t O_BUS;
  int slv_stops, mismatches, num_checks, cycles, k, stops0;
  row_t rows[8] = '{
    '{1'b0, 8'h00, 8'hA5, 1'b0, `I2C_ST_START, MODE_NONE},
    '{1'b1, 8'hA0, 8'h85, 1'b0, `I2C_ST_AW_ACK, MODE_MT},
    '{1'b1, 8'h5A, 8'h85, 1'b0, `I2C_ST_D_ACK, MODE_MT},
    '{1'b1, 8'hC3, 8'h85, 1'b1, `I2C_ST_D_NACK, MODE_MT},
    '{1'b0, 8'h00, 8'hB5, 1'b0, `I2C_ST_START, MODE_NONE},
    '{1'b1, 8'hA2, 8'h85, 1'b1, `I2C_ST_AW_NACK, MODE_MT},
    '{1'b0, 8'h00, 8'hA5, 1'b0, `I2C_ST_RSTART, MODE_NONE},
    '{1'b1, 8'hA1, 8'h85, 1'b1, `I2C_ST_AR_NACK, MODE_MR}};
  // Open drain with pull-ups: a line is high only when nobody pulls it
  assign scl_w = O_BUS.scl_oe_n;
  assign sda_w = O_BUS.sda_oe_n & ~slv_pull & ~other_pull;
  assign bus_in = '{scl: scl_w, sda: sda_w};
  i2c_mt_seq #(.QUARTER_NS(60)) DUT (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_BUS(bus_in), .O_BUS(O_BUS), .O_MODE(O_MODE), .O_IRQ(O_IRQ));
  i2c_slave_rx_model slave (.i_scl(scl_w), .i_sda(sda_w), .i_nack(nack), .o_pull(slv_pull),
    .o_byte(slv_byte), .o_stops(slv_stops));
  always #5 I_CLOCK = ~I_CLOCK;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("Checks: %0d, mismatches: %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask
  // One edge passes first so a release and the next setup never share a time step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge I_CLOCK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge I_CLOCK);
    penable <= 1'b1;
    do @(posedge I_CLOCK); while (O_PREADY !== 1'b1);
    rdata = O_PRDATA;
    perr = O_PSLVERR;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_flag();
    repeat (2) @(posedge I_CLOCK);
    for (k = 0; k < 3000 && O_IRQ !== 1'b1; k++) @(posedge I_CLOCK);
  endtask
  always @(posedge I_CLOCK) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    I_CLOCK = 1'b0;
    I_RSTN = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nack = 1'b0;
    other_pull = 1'b0;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    repeat (5) @(posedge I_CLOCK);
    check("bus at reset", 32'(O_BUS), 32'h3);
    check("irq at reset", O_IRQ, 1'b0);
    I_RSTN <= 1'b1;
    // Another master takes the bus, so our START has to wait
    other_pull <= 1'b1;
    apb(`I2C_OFS_STATUS, 1'b0, 32'h0);
    check("status reset", rdata, `I2C_STATUS_RST);
    apb(`I2C_OFS_CTRL, 1'b0, 32'h0);
    check("ctrl reset", rdata, `I2C_CTRL_RST);
    apb(`I2C_OFS_DATA, 1'b0, 32'h0);
    check("data reset", rdata, `I2C_DATA_RST);
    apb(12'h014, 1'b0, 32'h0);
    check("unmapped error", perr, 1'b1);
    check("unmapped data", rdata, 32'h0);
    for (int i = 0; i < 8; i++) begin
      nack <= rows[i].nack;
      if (rows[i].has_d) apb(`I2C_OFS_DATA, 1'b1, rows[i].d);
      apb(`I2C_OFS_CTRL, 1'b1, rows[i].ctrl);
      if (i == 0) begin
        repeat (60) @(posedge I_CLOCK);
        check("start while busy", O_BUS.sda_oe_n, 1'b1);
        other_pull <= 1'b0;
      end
      if (i == 2) apb(`I2C_OFS_DATA, 1'b1, 32'hFF);
      wait_flag();
      apb(`I2C_OFS_STATUS, 1'b0, 32'h0);
      check("status", rdata & 32'hF8, rows[i].st);
      repeat (20) @(posedge I_CLOCK);
      check("scl held", O_BUS.scl_oe_n, 1'b0);
      if (rows[i].has_d) begin
        check("slave byte", slv_byte, rows[i].d);
        check("mode", O_MODE, rows[i].mode);
      end
      if (i == 2) begin
        apb(`I2C_OFS_CTRL, 1'b0, 32'h0);
        check("collision bit", rdata[3], 1'b1);
      end
    end
    // ----------------------------------------
    // Hand-written cases
    // ----------------------------------------
    apb(`I2C_OFS_CTRL, 1'b1, 32'h04);
    apb(`I2C_OFS_CTRL, 1'b0, 32'h0);
    check("flag kept", rdata[7], 1'b1);
    check("irq masked", O_IRQ, 1'b0);
    apb(`I2C_OFS_CTRL, 1'b1, 32'h05);
    @(posedge I_CLOCK);
    check("irq enabled", O_IRQ, 1'b1);
    stops0 = slv_stops;
    apb(`I2C_OFS_CTRL, 1'b1, 32'h95);
    for (k = 0; k < 500 && 32'(O_BUS) !== 32'h3; k++) @(posedge I_CLOCK);
    repeat (30) @(posedge I_CLOCK);
    check("stop seen", slv_stops - stops0, 32'h1);
    apb(`I2C_OFS_CTRL, 1'b0, 32'h0);
    check("stop bit cleared", rdata[`I2C_CTRL_STOP], 1'b0);
    apb(`I2C_OFS_EVENT, 1'b0, 32'h0);
    check("events", rdata[1:0], 2'b11);
    apb(`I2C_OFS_MASK, 1'b1, 32'h2);
    @(posedge I_CLOCK);
    check("event irq", O_IRQ, 1'b1);
    apb(`I2C_OFS_EVENT, 1'b1, 32'h2);
    @(posedge I_CLOCK);
    check("event cleared", O_IRQ, 1'b0);
    // Arbitration lost in the first address bit
    nack <= 1'b0;
    apb(`I2C_OFS_CTRL, 1'b1, 32'hA5);
    wait_flag();
    apb(`I2C_OFS_DATA, 1'b1, 32'hA0);
    other_pull <= 1'b1;
    apb(`I2C_OFS_CTRL, 1'b1, 32'h85);
    wait_flag();
    apb(`I2C_OFS_STATUS, 1'b0, 32'h0);
    check("arb status", rdata & 32'hF8, `I2C_ST_ARB);
    apb(`I2C_OFS_EVENT, 1'b0, 32'h0);
    check("arb event", rdata[`I2C_EV_ARB], 1'b1);
    other_pull <= 1'b0;
    apb(`I2C_OFS_CTRL, 1'b1, 32'h84);
    repeat (30) @(posedge I_CLOCK);
    check("bus released", 32'(O_BUS), 32'h3);
    results();
  end
endmodule // i2c_master_transmit_sequencer_tb
